// ==== core/ptp_pkg.sv ====
package ptp_pkg;

  // ==========================================================================
  // widths: 10-bit values split into a low byte and a two-bit high byte
  localparam int CNT_W = 10;
  localparam int LO_W  = 8;
  localparam int HI_W  = 2;

  // ==========================================================================
  // reset values, the counter maximum and the period code for full range
  localparam logic [CNT_W-1:0] CNT_RST  = 10'h000;
  localparam logic [CNT_W-1:0] CAP_RST  = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3ff;
  localparam logic [CNT_W-1:0] PER_FULL = 10'h000;

  // ==========================================================================
  // operating modes, in mode field order 00, 01, 10, 11
  typedef enum logic [1:0] {
    MODE_CMP,
    MODE_CAP,
    MODE_SP,
    MODE_TC
  } ptp_mode_t;

  // output-action field: capture edge select, and the single-pulse setting
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;
  localparam logic [1:0] SP_ACTION = 2'h3;

  // capture-clear field
  localparam logic [1:0] TCLR_PERIOD = 2'h0;
  localparam logic [1:0] TCLR_RISE   = 2'h1;
  localparam logic [1:0] TCLR_FALL   = 2'h2;
  localparam logic [1:0] TCLR_BOTH   = 2'h3;

  // ==========================================================================
  // timing, in timer clocks (timer clock is clk_sys_in); halves kept as halves
  localparam int CAP_MIN_PULSE_TCK  = 2;
  localparam int LATCH_MAX_HALF_TCK = 3;
  localparam int LEVEL_DLY_HALF_TCK = 1;
  localparam int LATCH_CYC = (LATCH_MAX_HALF_TCK / 2 < 1) ? 1 : LATCH_MAX_HALF_TCK / 2;
  localparam int LEVEL_CYC = (LEVEL_DLY_HALF_TCK / 2 < 1) ? 1 : LEVEL_DLY_HALF_TCK / 2;

endpackage

// ==== core/ptp_edge_filter.sv ====
`timescale 1ns/1ps

// ============================================================================
// edge detector with minimum spacing between accepted edges
module ptp_edge_filter #(
  parameter int MIN_GAP = ptp_pkg::CAP_MIN_PULSE_TCK
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  localparam int GW = (MIN_GAP > 2) ? $clog2(MIN_GAP) : 1;
  localparam logic [GW-1:0] GAP_TOP = GW'(MIN_GAP - 1);

  logic          level_q;
  logic [GW-1:0] gap_q;
  logic          accept;

  // an edge closer than MIN_GAP to the last one waits; a short glitch comes out MIN_GAP clocks wide, or is lost if it lies inside the gap
  // short pulse stretch
  assign accept    = (pin_in != level_q) && (gap_q == GAP_TOP);
  assign rise_out  = accept & pin_in;
  assign fall_out  = accept & ~pin_in;
  assign level_out = level_q;

  // accepted level
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      level_q <= 1'b0;
    end else if (accept) begin
      level_q <= pin_in;
    end
  end

  // cycles since last accepted edge, saturating
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      gap_q <= GAP_TOP;
    end else if (accept) begin
      gap_q <= '0;
    end else if (gap_q != GAP_TOP) begin
      gap_q <= gap_q + GW'(1);
    end
  end

  property p_edge_spacing;
    @(posedge clk_sys_in) disable iff (rst_in)
    (rise_out || fall_out) |=> !(rise_out || fall_out);
  endproperty
  a_edge_spacing: assert property (p_edge_spacing)
    else $error("edges accepted back to back");

endmodule

// ==== core/ptp_counter.sv ====
`timescale 1ns/1ps

// ============================================================================
// up counter, clear has priority over count
module ptp_counter #(
  parameter int W = ptp_pkg::CNT_W
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  input  wire logic         clear_in,
  input  wire logic         inc_in,
  output logic      [W-1:0] count_out
);

  logic [W-1:0] count_q;

  // wraps past all ones when nothing clears it
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_q <= ptp_pkg::CNT_RST;
    end else if (clear_in) begin
      count_q <= ptp_pkg::CNT_RST;
    end else if (inc_in) begin
      count_q <= count_q + W'(1);
    end
  end

  assign count_out = count_q;

endmodule

// ==== core/ptp_timer.sv ====
`timescale 1ns/1ps

// Contract
// - trigger pin active edge sets the run bit in single-pulse mode
// - run bit rising starts counter and the pulse leading edge
// - compare A match or software clear drops run, ending the pulse
// - every compare A match in single-pulse mode raises the A flag
// - single-pulse counter zeroes only when run bit rises
// - single-pulse mode ignores period compare and counter-clear select
// - capture source is capture pin or trigger pin, chosen by selects
// - action field picks rising, falling or both; 11 captures nothing
// - capture-mode counter free runs until run bit falls
// - selected edge latches counter into capture A or B, raising flag
// - period match zeroes counter and raises period flag; zero means full
// - capture-clear field adds clear on rising, falling or either edge
// - edge select and clear select together steer capture to A or B
// - capture pulses under two timer clocks may be ignored
// - latch within 1.5 clocks; A flag then, level flag half clock later (code: level flag one clock after latch)
// - capture mode ignores clear select, initial state, polarity; no output
// - counter, A, B and period are 10 bits, low byte plus two bits
module ptp_timer #(
  parameter int CNT_W     = ptp_pkg::CNT_W,
  parameter int MIN_PULSE = ptp_pkg::CAP_MIN_PULSE_TCK
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_in,
  input  wire logic                     mode_sel_hi_in,
  input  wire logic                     mode_sel_lo_in,
  input  wire logic                     out_action_hi_in,
  input  wire logic                     out_action_lo_in,
  input  wire logic                     run_set_in,
  input  wire logic                     run_clr_in,
  input  wire logic                     counter_clear_sel_in,
  input  wire logic                     capture_clear_hi_in,
  input  wire logic                     capture_clear_lo_in,
  input  wire logic                     capture_source_sel_in,
  input  wire logic [1:0]               input_pin_sel_field_in,
  input  wire logic                     out_initial_state_in,
  input  wire logic                     out_polarity_in,
  input  wire logic [ptp_pkg::LO_W-1:0] compare_capture_a_lo_in,
  input  wire logic [ptp_pkg::HI_W-1:0] compare_capture_a_hi_in,
  input  wire logic [ptp_pkg::LO_W-1:0] period_compare_lo_in,
  input  wire logic [ptp_pkg::HI_W-1:0] period_compare_hi_in,
  input  wire logic                     ext_clock_trigger_pin_in,
  input  wire logic [3:0]               capture_pin_in,
  input  wire logic                     match_a_flag_clr_in,
  input  wire logic                     match_period_flag_clr_in,
  input  wire logic                     capture_level_flag_clr_in,
  output logic                          run_bit_out,
  output logic      [CNT_W-1:0]         counter_out,
  output logic      [CNT_W-1:0]         capture_a_out,
  output logic      [CNT_W-1:0]         capture_b_out,
  output logic                          match_a_flag_out,
  output logic                          match_period_flag_out,
  output logic                          capture_level_flag_out,
  output logic                          pulse_out
);

  // ==========================================================================
  // decoded controls
  ptp_pkg::ptp_mode_t mode;
  logic               sp_mode;
  logic               cap_mode;
  logic [1:0]         edge_sel;
  logic [1:0]         clr_sel;
  logic [CNT_W-1:0]   compare_capture_a;
  logic [CNT_W-1:0]   period;
  logic               idle_lvl;

  assign mode     = ptp_pkg::ptp_mode_t'({mode_sel_hi_in, mode_sel_lo_in});
  assign sp_mode  = (mode == ptp_pkg::MODE_SP);
  assign cap_mode = (mode == ptp_pkg::MODE_CAP);
  assign edge_sel = {out_action_hi_in, out_action_lo_in};
  assign clr_sel  = {capture_clear_hi_in, capture_clear_lo_in};
  assign compare_capture_a     = {compare_capture_a_hi_in, compare_capture_a_lo_in};
  assign period   = {period_compare_hi_in, period_compare_lo_in};
  assign idle_lvl = out_initial_state_in ^ out_polarity_in;

  // ==========================================================================
  // pin front end
  logic trig_rise;
  logic cap_src;
  logic cap_lvl;
  logic cap_rise;
  logic cap_fall;

  assign cap_src = capture_source_sel_in ? ext_clock_trigger_pin_in
                                         : capture_pin_in[input_pin_sel_field_in];

  // trigger pin edges, rising edge is the active one
  ptp_edge_filter #(.MIN_GAP(MIN_PULSE)) u_trig_filt (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     (ext_clock_trigger_pin_in),
    .level_out  (),
    .rise_out   (trig_rise),
    .fall_out   ()
  );

  // capture input edges; a spaced filter trades glitch immunity for latency
  ptp_edge_filter #(.MIN_GAP(MIN_PULSE)) u_cap_filt (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     (cap_src),
    .level_out  (cap_lvl),
    .rise_out   (cap_rise),
    .fall_out   (cap_fall)
  );

  // ==========================================================================
  // run bit
  logic             run_q;
  logic             run_d;
  logic             run_start;
  logic             run_stop;
  logic             run_rise;
  logic             match_a;
  logic [CNT_W-1:0] cnt;

  // single pulse never reads the action field; capture is gated by cap_mode
  assign match_a   = sp_mode & run_q & (cnt == compare_capture_a);
  assign run_start = run_set_in | (sp_mode & trig_rise);
  assign run_stop  = run_clr_in | match_a;
  // a start wins over a stop landing in the same cycle
  assign run_d     = run_start ? 1'b1 : (run_stop ? 1'b0 : run_q);
  assign run_rise  = run_d & ~run_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // ==========================================================================
  // counter control
  logic cap_armed;
  logic period_hit;
  logic clr_edge;
  logic cap_fire;
  logic cap_to_b;
  logic cnt_clear;
  logic cnt_inc;

  assign cap_armed = cap_mode & run_q;

  // period match, zero means full range
  assign period_hit = cap_armed & ((period == ptp_pkg::PER_FULL) ? (cnt == ptp_pkg::CNT_MAX)
                                                                 : (cnt == period));

  always_comb begin
    case (clr_sel)
      ptp_pkg::TCLR_RISE: clr_edge = cap_armed & cap_rise;
      ptp_pkg::TCLR_FALL: clr_edge = cap_armed & cap_fall;
      ptp_pkg::TCLR_BOTH: clr_edge = cap_armed & (cap_rise | cap_fall);
      default:            clr_edge = 1'b0;
    endcase
  end

  // edge select, 11 blocks capture only
  always_comb begin
    case (edge_sel)
      ptp_pkg::EDGE_RISE: cap_fire = cap_armed & cap_rise;
      ptp_pkg::EDGE_FALL: cap_fire = cap_armed & cap_fall;
      ptp_pkg::EDGE_BOTH: cap_fire = cap_armed & (cap_rise | cap_fall);
      default:            cap_fire = 1'b0;
    endcase
  end

  // falling edges go to B once a capture clear is in use
  assign cap_to_b = (clr_sel != ptp_pkg::TCLR_PERIOD) & cap_fall;

  // single pulse only clears on run rising
  // capture mode keeps counting regardless of the input
  assign cnt_clear = run_rise | period_hit | clr_edge;
  // count while running; a match freezes the count where it stopped
  assign cnt_inc   = run_q & ((sp_mode & ~match_a) | cap_mode);

  ptp_counter #(.W(CNT_W)) u_cnt (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .clear_in   (cnt_clear),
    .inc_in     (cnt_inc),
    .count_out  (cnt)
  );

  // ==========================================================================
  // capture registers
  logic [CNT_W-1:0] cap_a_q;
  logic [CNT_W-1:0] cap_b_q;

  // value lands one clock after edge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cap_a_q <= ptp_pkg::CAP_RST;
      cap_b_q <= ptp_pkg::CAP_RST;
    end else if (cap_fire) begin
      if (cap_to_b) begin
        cap_b_q <= cnt;
      end else begin
        cap_a_q <= cnt;
      end
    end
  end

  // ==========================================================================
  // flags; a hardware set wins over a clear in the same cycle
  logic match_a_flag_q;
  logic match_p_flag_q;
  logic level_flag_q;
  logic level_pend_q;

  // match flag in single pulse, also set on capture
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      match_a_flag_q <= 1'b0;
    end else if (match_a | cap_fire) begin
      match_a_flag_q <= 1'b1;
    end else if (match_a_flag_clr_in) begin
      match_a_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      match_p_flag_q <= 1'b0;
    end else if (period_hit) begin
      match_p_flag_q <= 1'b1;
    end else if (match_period_flag_clr_in) begin
      match_p_flag_q <= 1'b0;
    end
  end

  // level flag one clock after latch; meaningless with clear 00
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      level_pend_q <= 1'b0;
      level_flag_q <= 1'b0;
    end else begin
      level_pend_q <= cap_fire;
      if (level_pend_q) begin
        level_flag_q <= cap_lvl;
      end else if (capture_level_flag_clr_in) begin
        level_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // pulse output, follows run_d so leading edge meets run_q
  logic pulse_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulse_q <= 1'b0;
    end else if (sp_mode) begin
      pulse_q <= run_d ^ idle_lvl;
    end else if (cap_mode) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= idle_lvl;
    end
  end

  // ==========================================================================
  // outputs
  assign run_bit_out            = run_q;
  assign counter_out            = cnt;
  assign capture_a_out          = cap_a_q;
  assign capture_b_out          = cap_b_q;
  assign match_a_flag_out       = match_a_flag_q;
  assign match_period_flag_out  = match_p_flag_q;
  assign capture_level_flag_out = level_flag_q;
  assign pulse_out              = pulse_q;

  // ==========================================================================
  // checks
  property p_trig_sets_run;
    @(posedge clk_sys_in) disable iff (rst_in)
    (sp_mode && trig_rise) |=> run_q;
  endproperty
  a_trig_sets_run: assert property (p_trig_sets_run)
    else $error("trigger edge did not set run");

  property p_start_zero;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(run_q) |-> (cnt == ptp_pkg::CNT_RST);
  endproperty
  a_start_zero: assert property (p_start_zero)
    else $error("counter not zero at run rise");

  sequence s_sp_match;
    sp_mode && run_q && (cnt == compare_capture_a) && !run_start;
  endsequence

  property p_match_ends;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_sp_match |=> (!run_q && match_a_flag_q && (pulse_q == idle_lvl));
  endproperty
  a_match_ends: assert property (p_match_ends)
    else $error("match did not end pulse");

  property p_match_flag;
    @(posedge clk_sys_in) disable iff (rst_in)
    (sp_mode && run_q && (cnt == compare_capture_a)) |=> match_a_flag_q;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match flag missing");

  property p_sp_no_zero;
    @(posedge clk_sys_in) disable iff (rst_in)
    (sp_mode && (cnt != ptp_pkg::CNT_RST) && (cnt != ptp_pkg::CNT_MAX) && !run_rise)
      |=> (cnt != ptp_pkg::CNT_RST);
  endproperty
  a_sp_no_zero: assert property (p_sp_no_zero)
    else $error("single pulse counter zeroed");

  property p_no_capture;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cap_mode && edge_sel == ptp_pkg::EDGE_NONE) |=> ($stable(cap_a_q) && $stable(cap_b_q));
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("capture with edge select 11");

  property p_free_run;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cap_armed && !period_hit && !clr_edge) |=> (cnt == $past(cnt) + CNT_W'(1));
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("capture counter did not advance");

  sequence s_latched;
    ##1 (match_a_flag_q && ((cap_a_q == $past(cnt)) || (cap_b_q == $past(cnt))));
  endsequence

  sequence s_level_after;
    (level_flag_q == $past(cap_lvl));
  endsequence

  property p_capture_steps;
    @(posedge clk_sys_in) disable iff (rst_in)
    cap_fire |-> s_latched ##1 s_level_after;
  endproperty
  a_capture_steps: assert property (p_capture_steps)
    else $error("capture latch or flags late");

  property p_period_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    period_hit |=> ((cnt == ptp_pkg::CNT_RST) && match_p_flag_q);
  endproperty
  a_period_clear: assert property (p_period_clear)
    else $error("period match did not clear");

  property p_pulse_tracks_run;
    @(posedge clk_sys_in) disable iff (rst_in)
    sp_mode |=> ((pulse_q ^ $past(idle_lvl)) == run_q);
  endproperty
  a_pulse_tracks_run: assert property (p_pulse_tracks_run)
    else $error("pulse not tied to run bit");

  property p_cap_no_output;
    @(posedge clk_sys_in) disable iff (rst_in)
    cap_mode |=> !pulse_q;
  endproperty
  a_cap_no_output: assert property (p_cap_no_output)
    else $error("output driven in capture mode");

endmodule

// ==== verif/ptp_pin_model.sv ====
`timescale 1ns/1ps

// ==========
// pin driver for trigger and capture pins
module ptp_pin_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       go_in,
  input  wire logic [2:0] sel_in,
  input  wire logic [7:0] width_in,
  output logic            trig_pin_out,
  output logic      [3:0] cap_pins_out,
  output logic            busy_out
);
  logic [7:0] left_q;
  logic [2:0] sel_q;

  // pulses held whole width; widths below two are not clamped
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      left_q <= 8'h00;
      sel_q  <= 3'h0;
    end else if (go_in && left_q == 8'h00) begin
      left_q <= width_in;
      sel_q  <= sel_in;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  // trigger pin only ever a capture or trigger source
  // idle pins rest low, as if pulled down
  always_comb begin
    busy_out     = (left_q != 8'h00);
    trig_pin_out = busy_out && sel_q[2];
    cap_pins_out = 4'h0;
    if (busy_out && !sel_q[2]) begin
      cap_pins_out[sel_q[1:0]] = 1'b1;
    end
  end
endmodule

// ==== verif/ptp_timer_tb.sv ====
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

// ==========
// bench for the periodic timer
module ptp_timer_tb;
  logic       clk_sys_in = 0, rst_in = 1, run_set_in = 0, run_clr_in = 0;
  logic       mode_sel_hi_in = 0, mode_sel_lo_in = 0, out_action_hi_in = 0, out_action_lo_in = 0;
  logic       counter_clear_sel_in = 0, capture_clear_hi_in = 0, capture_clear_lo_in = 0;
  logic       capture_source_sel_in = 0, out_initial_state_in = 1, out_polarity_in = 0;
  logic       match_a_flag_clr_in = 0, match_period_flag_clr_in = 0, capture_level_flag_clr_in = 0;
  logic [1:0] input_pin_sel_field_in = 0;
  logic [9:0] compare_capture_a = 10'h002, per = 10'h000, v;
  logic       ext_clock_trigger_pin_in, go = 0, busy;
  logic [3:0] capture_pin_in;
  logic [2:0] sel = 0;
  logic [7:0] wid = 8'h02;
  logic       run_bit_out, match_a_flag_out, match_period_flag_out, capture_level_flag_out, pulse_out;
  logic [9:0] counter_out, capture_a_out, capture_b_out;
  int         err_count = 0, checks_done = 0, cyc = 0, n;

  ptp_timer dut (.clk_sys_in, .rst_in, .mode_sel_hi_in, .mode_sel_lo_in, .out_action_hi_in,
    .out_action_lo_in, .run_set_in, .run_clr_in, .counter_clear_sel_in, .capture_clear_hi_in,
    .capture_clear_lo_in, .capture_source_sel_in, .input_pin_sel_field_in, .out_initial_state_in,
    .out_polarity_in, .compare_capture_a_lo_in(compare_capture_a[7:0]), .compare_capture_a_hi_in(compare_capture_a[9:8]),
    .period_compare_lo_in(per[7:0]), .period_compare_hi_in(per[9:8]), .ext_clock_trigger_pin_in,
    .capture_pin_in, .match_a_flag_clr_in, .match_period_flag_clr_in, .capture_level_flag_clr_in,
    .run_bit_out, .counter_out, .capture_a_out, .capture_b_out, .match_a_flag_out,
    .match_period_flag_out, .capture_level_flag_out, .pulse_out);

  ptp_pin_model pins (.clk_sys_in, .rst_in, .go_in(go), .sel_in(sel), .width_in(wid),
    .trig_pin_out(ext_clock_trigger_pin_in), .cap_pins_out(capture_pin_in), .busy_out(busy));

  // clock and hang guard, ceiling well above the longest run
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // reset with new controls; first request at the next edge
  task automatic cfg(input logic [1:0] m, e, c, input logic s, input logic [1:0] p);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    {mode_sel_hi_in, mode_sel_lo_in} <= m;
    {out_action_hi_in, out_action_lo_in} <= e;
    {capture_clear_hi_in, capture_clear_lo_in} <= c;
    capture_source_sel_in <= s;
    input_pin_sel_field_in <= p;
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
  endtask

  task automatic strobe(input logic clr);
    @(posedge clk_sys_in);
    if (clr) run_clr_in <= 1'b1;
    else run_set_in <= 1'b1;
    @(posedge clk_sys_in);
    run_clr_in <= 1'b0;
    run_set_in <= 1'b0;
  endtask

  task automatic pin(input logic [2:0] s, input logic [7:0] w);
    @(posedge clk_sys_in);
    go  <= 1'b1;
    sel <= s;
    wid <= w;
    @(posedge clk_sys_in);
    go <= 1'b0;
  endtask

  // never read run_bit_out in the time step of the edge that launches it
  task automatic wait_run();
    @(negedge clk_sys_in);
    for (n = 0; n < 12 && run_bit_out !== 1'b1; n++) @(negedge clk_sys_in);
  endtask

  // single pulse from the trigger pin, width from compare A
  task automatic t_sp_trig();
    cfg(2'h2, ptp_pkg::SP_ACTION, 2'h0, 1'b0, 2'h0);
    // pulse_out sits at 0 for one clock after reset, idle level after that
    repeat (2) @(negedge clk_sys_in);
    `CHK(pulse_out, 1'b1)
    pin(3'h4, 8'h04);
    wait_run();
    `CHK(run_bit_out, 1'b1)
    `CHK(counter_out, 10'h000)
    `CHK(pulse_out, 1'b0)
    for (n = 0; n < 20 && run_bit_out === 1'b1; n++) @(negedge clk_sys_in);
    `CHK(n == 3, 1'b1)
    `CHK(counter_out, 10'h002)
    `CHK(match_a_flag_out, 1'b1)
    `CHK(pulse_out, 1'b1)
    @(posedge clk_sys_in);
    match_a_flag_clr_in <= 1'b1;
    @(posedge clk_sys_in);
    match_a_flag_clr_in <= 1'b0;
    @(negedge clk_sys_in);
    `CHK(match_a_flag_out, 1'b0)
  endtask

  // software start and stop; period and clear select must not matter
  task automatic t_sp_soft();
    @(posedge clk_sys_in);
    compare_capture_a <= 10'h3ff;
    per <= 10'h001;
    counter_clear_sel_in <= 1'b1;
    cfg(2'h2, ptp_pkg::SP_ACTION, 2'h0, 1'b0, 2'h0);
    strobe(1'b0);
    wait_run();
    repeat (5) @(negedge clk_sys_in);
    `CHK(counter_out, 10'h005)
    strobe(1'b1);
    @(negedge clk_sys_in);
    `CHK(run_bit_out, 1'b0)
    `CHK(pulse_out, 1'b1)
    v = counter_out;
    repeat (3) @(negedge clk_sys_in);
    `CHK(counter_out, v)
  endtask

  // capture mode, one pulse on the chosen pin near count 20
  task automatic t_cap(input logic [1:0] e, c, input logic s, input logic [1:0] p, input logic ea, eb);
    @(posedge clk_sys_in);
    per <= 10'h000;
    cfg(2'h1, e, c, s, p);
    strobe(1'b0);
    repeat (18) @(posedge clk_sys_in);
    pin({s, p}, 8'h04);
    repeat (9) @(negedge clk_sys_in);
    `CHK(capture_a_out != 10'h000, ea)
    `CHK(capture_b_out != 10'h000, eb)
    `CHK(match_a_flag_out, ea | eb)
    `CHK(counter_out < 10'h00c, c != 2'h0)
    `CHK(pulse_out, 1'b0)
    if (c != 2'h0 && e != ptp_pkg::EDGE_BOTH) `CHK(capture_level_flag_out, e == 2'h0)
    if (ea && e == ptp_pkg::EDGE_RISE) `CHK(capture_a_out >= 10'd18 && capture_a_out <= 10'd23, 1'b1)
  endtask

  // period wrap, flag clear, and hold after stop
  task automatic t_per(input logic [9:0] p);
    logic [9:0] mx;
    mx = 10'h000;
    @(posedge clk_sys_in);
    per <= p;
    cfg(2'h1, ptp_pkg::EDGE_NONE, ptp_pkg::TCLR_PERIOD, 1'b0, 2'h0);
    strobe(1'b0);
    for (n = 0; n < 1100 && match_period_flag_out !== 1'b1; n++) begin
      @(negedge clk_sys_in);
      if (counter_out > mx) mx = counter_out;
    end
    `CHK(match_period_flag_out, 1'b1)
    `CHK(mx, (p == 10'h000) ? 10'h3ff : p)
    `CHK(counter_out, 10'h000)
    @(posedge clk_sys_in);
    match_period_flag_clr_in <= 1'b1;
    @(posedge clk_sys_in);
    match_period_flag_clr_in <= 1'b0;
    @(negedge clk_sys_in);
    `CHK(match_period_flag_out, 1'b0)
    strobe(1'b1);
    @(negedge clk_sys_in);
    v = counter_out;
    repeat (3) @(negedge clk_sys_in);
    `CHK(counter_out, v)
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_sp_trig();
    t_sp_soft();
    t_cap(ptp_pkg::EDGE_RISE, ptp_pkg::TCLR_PERIOD, 1'b0, 2'h2, 1'b1, 1'b0);
    t_cap(ptp_pkg::EDGE_FALL, ptp_pkg::TCLR_PERIOD, 1'b0, 2'h1, 1'b1, 1'b0);
    t_cap(ptp_pkg::EDGE_NONE, ptp_pkg::TCLR_PERIOD, 1'b0, 2'h3, 1'b0, 1'b0);
    t_cap(ptp_pkg::EDGE_BOTH, ptp_pkg::TCLR_RISE, 1'b0, 2'h0, 1'b1, 1'b1);
    t_cap(ptp_pkg::EDGE_FALL, ptp_pkg::TCLR_FALL, 1'b0, 2'h2, 1'b0, 1'b1);
    t_cap(ptp_pkg::EDGE_RISE, ptp_pkg::TCLR_BOTH, 1'b1, 2'h0, 1'b1, 1'b0);
    t_per(10'h005);
    t_per(10'h000);
    final_report();
  end
endmodule
